// >>> spm_media_if.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - port type caught STRAP_SETTLE enabled cycles after reset release, held
// - MII and RMII run only 10/100
// - TX pins feed switch, RX pins leave it
// - MII moves nibbles at quarter bit rate
// - MII has no COL/CRS, full duplex
// - MII chosen by two type straps
// - role strap picks MII PHY or MAC
// - role swaps only the two clock pins
// - PHY role drives both clocks, RX group
// - MAC role takes both clocks from PHY
// - RMII times both ways from one reference
// - RMII moves one dibit per reference cycle at 100, per ten at 10
// - strap high: reference comes on input
// - strap low: drive reference from system clock once crystal toggles
// - toward MAC sample TX, drive RX group
// - RMII has no roles, TX error unused
module spm_media_if (
  input  wire logic       CLK,                         // system clock
  input  wire logic       RST_N,                       // sync reset
  input  wire logic       CE,                          // clock enable
  input  wire logic       SPEED_10,                    // 1 selects 10 Mbps
  input  wire logic       ROLE_OR_CLOCK_SOURCE_STRAP,  // role / reference strap
  input  wire logic       SPEED_SELECT_STRAP,          // speed strap
  input  wire logic       INTERFACE_TYPE_STRAP_HI,     // type strap high
  input  wire logic       INTERFACE_TYPE_STRAP_LO,     // type strap low
  input  wire logic       CRYSTAL_CLOCK_INPUT,         // 25 MHz crystal
  input  wire logic       TX_CLK_I,                    // tx clock / reference in
  output logic            TX_CLK_O,                    // tx clock out
  output var  logic       TX_CLK_OE,                   // tx clock drive
  input  wire logic       RX_CLK_I,                    // rx clock in
  output logic            RX_CLK_O,                    // rx clock / reference out
  output var  logic       RX_CLK_OE,                   // rx clock drive
  input  wire logic       TX_EN,                       // tx enable / carrier valid
  input  wire logic       TX_ER,                       // tx error
  input  wire logic [3:0] TXD,                         // tx data
  output var  logic       RX_DV,                       // rx valid / enable
  output var  logic       RX_ER,                       // rx error
  output var  logic [3:0] RXD,                         // rx data
  input  wire logic [7:0] SW_TX_DATA,                  // byte to line
  input  wire logic       SW_TX_LAST,                  // last byte of frame
  input  wire logic       SW_TX_VALID,                 // byte offered
  output logic            SW_TX_READY,                 // byte accepted
  output var  logic [7:0] SW_RX_DATA,                  // byte from line
  output var  logic       SW_RX_ERR,                   // byte carried error
  output var  logic       SW_RX_VALID,                 // byte strobe
  output var  logic       SW_RX_END,                   // frame ended
  output var  logic       CFG_READY,                   // straps caught
  output logic      [1:0] CFG_TYPE,                    // port type
  output var  logic       CFG_PHY_ROLE,                // MII PHY role
  output var  logic       CFG_CLK_OUT,                 // RMII drives reference
  output var  logic [1:0] CFG_SPEED,                   // line speed
  output var  logic       CFG_SPEED_WARN,              // MII speed strap not 100/10
  output var  logic       CFG_UNSUPPORTED              // type not served here
);
  // two-stage synchronisers for pins
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic        s_en;
  logic        s_er;
  logic [3:0]  s_txd;
  logic        s_tclk;
  logic        s_rclk;
  logic        s_xtal;
  logic        s_role;
  logic        s_speed;
  logic        s_thi;
  logic        s_tlo;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
    end else if (CE) begin
      sync1 <= {TX_EN, TX_ER, TXD, TX_CLK_I, RX_CLK_I, CRYSTAL_CLOCK_INPUT,
                ROLE_OR_CLOCK_SOURCE_STRAP, SPEED_SELECT_STRAP,
                INTERFACE_TYPE_STRAP_HI, INTERFACE_TYPE_STRAP_LO};
      sync2 <= sync1;
    end
  end

  assign {s_en, s_er, s_txd, s_tclk, s_rclk, s_xtal, s_role, s_speed, s_thi, s_tlo} = sync2;

  // configuration capture
  logic [1:0]         settle;
  logic               cfg_done;
  spm_pkg::spm_type_t cfg_type;
  logic               cfg_role;
  logic               speed10;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      settle          <= 2'h0;
      cfg_done        <= 1'b0;
      cfg_type        <= spm_pkg::SPM_MII;
      cfg_role        <= 1'b0;
      speed10         <= 1'b0;
      CFG_READY       <= 1'b0;
      CFG_PHY_ROLE    <= 1'b0;
      CFG_CLK_OUT     <= 1'b0;
      CFG_SPEED       <= spm_pkg::SPD_10;
      CFG_SPEED_WARN  <= 1'b0;
      CFG_UNSUPPORTED <= 1'b0;
    end else if (CE && !cfg_done) begin
      if (settle != spm_pkg::STRAP_SETTLE) begin
        settle <= settle + 2'h1;
      end else begin
        cfg_done  <= 1'b1;
        CFG_READY <= 1'b1;
        cfg_type  <= spm_pkg::spm_type_t'({s_thi, s_tlo});
        cfg_role  <= s_role;
        speed10   <= SPEED_10;
        CFG_PHY_ROLE <= {s_thi, s_tlo} == spm_pkg::SPM_MII && s_role == spm_pkg::ROLE_STRAP_PHY;
        CFG_CLK_OUT  <= {s_thi, s_tlo} == spm_pkg::SPM_RMII && s_role != spm_pkg::ROLE_STRAP_REF_IN;
        CFG_SPEED_WARN <= {s_thi, s_tlo} == spm_pkg::SPM_MII
                          && s_speed != spm_pkg::SPEED_STRAP_100_10;
        CFG_UNSUPPORTED <= {s_thi, s_tlo} == spm_pkg::SPM_RGMII
                           || {s_thi, s_tlo} == spm_pkg::SPM_RSVD;
        if ({s_thi, s_tlo} == spm_pkg::SPM_RGMII) begin
          CFG_SPEED <= (s_speed != spm_pkg::SPEED_STRAP_100_10) ? spm_pkg::SPD_1000
                                                                  : spm_pkg::SPD_100;
        end else begin
          CFG_SPEED <= SPEED_10 ? spm_pkg::SPD_10 : spm_pkg::SPD_100;
        end
      end
    end
  end

  assign CFG_TYPE = cfg_type;

  logic is_mii;
  logic is_rmii;
  logic active;
  logic gen_mii;
  logic gen_ref;
  logic use_gen;

  assign is_mii  = cfg_type == spm_pkg::SPM_MII;
  assign is_rmii = cfg_type == spm_pkg::SPM_RMII;
  assign active  = cfg_done && (is_mii || is_rmii);
  assign gen_mii = is_mii && cfg_role == spm_pkg::ROLE_STRAP_PHY;
  assign gen_ref = is_rmii && cfg_role != spm_pkg::ROLE_STRAP_REF_IN;
  assign use_gen = gen_mii || gen_ref;

  // link clock edges seen on pins
  logic tclk_d;
  logic rclk_d;
  logic xtal_d;
  logic xtal_seen;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tclk_d    <= 1'b0;
      rclk_d    <= 1'b0;
      xtal_d    <= 1'b0;
      xtal_seen <= 1'b0;
    end else if (CE) begin
      tclk_d <= s_tclk;
      rclk_d <= s_rclk;
      xtal_d <= s_xtal;
      if (s_xtal != xtal_d) begin
        xtal_seen <= 1'b1;
      end
    end
  end

  // generated link clock
  logic       g_rise;
  logic       g_fall;
  logic       gclk;
  logic       g_run;
  logic [7:0] g_half;

  assign g_run  = active && (gen_mii || (gen_ref && xtal_seen));
  assign g_half = gen_ref ? spm_pkg::RMII_HALF
                : (speed10 ? spm_pkg::MII10_HALF : spm_pkg::MII100_HALF);

  spm_clkgen u_clkgen (
    .clk   (CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .run   (g_run),
    .half  (g_half),
    .clk_o (gclk),
    .rise  (g_rise),
    .fall  (g_fall)
  );

  assign TX_CLK_O = gclk;
  assign RX_CLK_O = gclk;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_CLK_OE <= 1'b0;
      RX_CLK_OE <= 1'b0;
    end else if (CE) begin
      TX_CLK_OE <= active && gen_mii;
      RX_CLK_OE <= active && (gen_mii || gen_ref);
    end
  end

  // line steps; reference input ignored while driving it
  logic       t_rise;
  logic       r_rise;
  logic       in_tick;
  logic       out_tick;
  logic [3:0] slot_cnt;
  logic       slot;
  logic       in_step;
  logic       out_step;

  assign t_rise   = s_tclk && !tclk_d;
  assign r_rise   = s_rclk && !rclk_d;
  assign in_tick  = use_gen ? g_fall : t_rise;
  assign out_tick = use_gen ? g_fall : (is_mii ? r_rise : t_rise);
  assign slot     = !is_rmii || !speed10 || slot_cnt == 4'h0;
  assign in_step  = CE && active && in_tick && slot;
  assign out_step = CE && active && out_tick && slot;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      slot_cnt <= 4'h0;
    end else if (CE && active && is_rmii && in_tick) begin
      slot_cnt <= (slot_cnt == spm_pkg::RMII10_REPEAT - 4'h1) ? 4'h0 : slot_cnt + 4'h1;
    end
  end

  logic [2:0] units_m1;
  assign units_m1 = is_rmii ? spm_pkg::RMII_UNITS_M1 : spm_pkg::MII_UNITS_M1;

  function automatic logic [3:0] unit_of(input logic [7:0] sr, input logic rmii);
    return rmii ? {2'h0, sr[1:0]} : sr[3:0];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] sr, input logic rmii);
    return rmii ? {2'h0, sr[7:2]} : {4'h0, sr[7:4]};
  endfunction

  // ingress: TX-named pins into the switch, low unit first
  logic [7:0] ig_sr;
  logic [7:0] next_ig;
  logic [2:0] ig_cnt;
  logic       ig_on;
  logic       ig_err;

  assign next_ig = is_rmii ? {s_txd[1:0], ig_sr[7:2]} : {s_txd, ig_sr[7:4]};

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ig_sr       <= 8'h00;
      ig_cnt      <= 3'h0;
      ig_on       <= 1'b0;
      ig_err      <= 1'b0;
      SW_RX_DATA  <= 8'h00;
      SW_RX_ERR   <= 1'b0;
      SW_RX_VALID <= 1'b0;
      SW_RX_END   <= 1'b0;
    end else if (CE) begin
      SW_RX_VALID <= 1'b0;
      SW_RX_END   <= 1'b0;
      if (in_step) begin
        if (s_en) begin
          ig_on <= 1'b1;
          ig_sr <= next_ig;
          if (ig_cnt == units_m1) begin
            ig_cnt      <= 3'h0;
            ig_err      <= 1'b0;
            SW_RX_DATA  <= next_ig;
            SW_RX_ERR   <= ig_err || (is_mii && s_er);
            SW_RX_VALID <= 1'b1;
          end else begin
            ig_cnt <= ig_cnt + 3'h1;
            ig_err <= ig_err || (is_mii && s_er);
          end
        end else begin
          // a partial byte at frame end is dropped
          ig_cnt <= 3'h0;
          ig_err <= 1'b0;
          ig_on  <= 1'b0;
          if (ig_on) begin
            SW_RX_END <= 1'b1;
          end
        end
      end
    end
  end

  // egress buffer from the switch
  logic [spm_pkg::FIFO_WIDTH-1:0] f_data;
  logic                           f_valid;
  logic                           f_pop;

  spm_fifo #(
    .WIDTH (spm_pkg::FIFO_WIDTH),
    .DEPTH (spm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .in_valid  (SW_TX_VALID),
    .in_data   ({SW_TX_LAST, SW_TX_DATA}),
    .in_ready  (SW_TX_READY),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  // egress: switch out onto RX-named pins, runs beside ingress
  spm_pkg::spm_eg_t eg_state;
  logic [7:0]       eg_sr;
  logic [2:0]       eg_cnt;
  logic             eg_last;
  logic [7:0]       eg_gap;
  logic             eg_load;

  assign eg_load = f_valid && (eg_state == spm_pkg::EG_IDLE
                   || (eg_state == spm_pkg::EG_SEND && eg_cnt == 3'h0 && !eg_last));
  assign f_pop   = out_step && eg_load;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      eg_state <= spm_pkg::EG_IDLE;
      eg_sr    <= 8'h00;
      eg_cnt   <= 3'h0;
      eg_last  <= 1'b0;
      eg_gap   <= 8'h00;
      RX_DV    <= 1'b0;
      RX_ER    <= 1'b0;
      RXD      <= 4'h0;
    end else if (CE && !active) begin
      eg_state <= spm_pkg::EG_IDLE;
      RX_DV    <= 1'b0;
      RX_ER    <= 1'b0;
      RXD      <= 4'h0;
    end else if (out_step) begin
      if (eg_load) begin
        eg_state <= spm_pkg::EG_SEND;
        eg_sr    <= shift_out(f_data[7:0], is_rmii);
        eg_cnt   <= units_m1;
        eg_last  <= f_data[spm_pkg::LAST_BIT];
        RX_DV    <= 1'b1;
        RX_ER    <= 1'b0;
        RXD      <= unit_of(f_data[7:0], is_rmii);
      end else begin
        unique case (eg_state)
          spm_pkg::EG_IDLE: begin
            RX_DV <= 1'b0;
            RX_ER <= 1'b0;
            RXD   <= 4'h0;
          end
          spm_pkg::EG_SEND: begin
            if (eg_cnt != 3'h0) begin
              eg_cnt <= eg_cnt - 3'h1;
              eg_sr  <= shift_out(eg_sr, is_rmii);
              RXD    <= unit_of(eg_sr, is_rmii);
            end else if (eg_last) begin
              eg_state <= spm_pkg::EG_GAP;
              eg_gap   <= is_rmii ? spm_pkg::IFG_DIBITS : spm_pkg::IFG_NIBBLES;
              RX_DV    <= 1'b0;
              RX_ER    <= 1'b0;
              RXD      <= 4'h0;
            end else begin
              // switch starved mid-frame: mark the frame bad
              RX_ER <= 1'b1;
              RXD   <= 4'h0;
            end
          end
          spm_pkg::EG_GAP: begin
            eg_gap <= eg_gap - 8'h01;
            if (eg_gap == 8'h01) begin
              eg_state <= spm_pkg::EG_IDLE;
            end
          end
          default: begin
            eg_state <= spm_pkg::EG_IDLE;
          end
        endcase
      end
    end
  end

  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  sequence mii_cycle_s;
    ##2 $fell(TX_CLK_O) ##2 $rose(TX_CLK_O);
  endsequence

  cfg_hold_a: assert property (
    cfg_done |=> cfg_done && $stable(cfg_type) && $stable(cfg_role))
    else $error("port configuration changed after capture");

  no_gig_a: assert property (
    cfg_done && cfg_type != spm_pkg::SPM_RGMII |=> CFG_SPEED != spm_pkg::SPD_1000)
    else $error("gigabit speed on a 10/100 variant");

  dv_source_a: assert property (
    $rose(RX_DV) |-> $past(f_valid) && $past(out_step))
    else $error("rx valid rose without a buffered byte");

  mii_rate_a: assert property (
    gen_mii && !speed10 && TX_CLK_OE && $rose(TX_CLK_O) |-> mii_cycle_s)
    else $error("generated MII clock not 25 MHz");

  role_clk_a: assert property (
    cfg_done && is_mii |=> TX_CLK_OE == (cfg_role == spm_pkg::ROLE_STRAP_PHY)
                           && RX_CLK_OE == TX_CLK_OE)
    else $error("MII clock directions do not follow role");

  ref_mode_a: assert property (
    cfg_done && is_rmii |=> !TX_CLK_OE && RX_CLK_OE == !cfg_role)
    else $error("RMII reference direction wrong");

  dibit_only_a: assert property (
    cfg_done && is_rmii |-> RXD[3:2] == 2'h0)
    else $error("RMII drove upper data bits");

  byte_strobe_a: assert property (
    SW_RX_VALID |=> !SW_RX_VALID)
    else $error("ingress byte strobes back to back");

  quiet_reset_a: assert property (
    !cfg_done |-> !RX_DV && !RX_ER && RXD == 4'h0 && !TX_CLK_OE && !RX_CLK_OE)
    else $error("port active before configuration");
endmodule
`default_nettype wire

// >>> spm_pkg.sv
package spm_pkg;

  // system clock and link clock periods
  localparam int CLK_PERIOD_NS      = 10;
  localparam int MII100_PERIOD_NS   = 40;
  localparam int MII10_PERIOD_NS    = 400;
  localparam int RMII_REF_PERIOD_NS = 20;

  // half periods of generated link clocks, in system cycles
  localparam logic [7:0] MII100_HALF = 8'(MII100_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] MII10_HALF  = 8'(MII10_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [7:0] RMII_HALF   = 8'(RMII_REF_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // reference cycles per dibit at 10 Mbps in RMII
  localparam logic [3:0] RMII10_REPEAT = 4'hA;

  // inter-frame gap in line units
  localparam logic [7:0] IFG_NIBBLES = 8'h18;
  localparam logic [7:0] IFG_DIBITS  = 8'h30;

  // line units per byte, minus one
  localparam logic [2:0] MII_UNITS_M1  = 3'h1;
  localparam logic [2:0] RMII_UNITS_M1 = 3'h3;

  // enabled cycles after reset release before straps are caught
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // strap levels
  localparam logic ROLE_STRAP_PHY       = 1'b1;
  localparam logic ROLE_STRAP_REF_IN    = 1'b1;
  localparam logic SPEED_STRAP_100_10   = 1'b0;

  // egress buffer shape and word layout
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int LAST_BIT   = 8;

  typedef enum logic [1:0] {
    SPM_MII   = 2'b00,
    SPM_RMII  = 2'b01,
    SPM_RSVD  = 2'b10,
    SPM_RGMII = 2'b11
  } spm_type_t;

  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10
  } spm_speed_t;

  typedef enum logic [1:0] {
    EG_IDLE = 2'b00,
    EG_SEND = 2'b01,
    EG_GAP  = 2'b10
  } spm_eg_t;

endpackage

// >>> spm_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module spm_fifo #(
  parameter int WIDTH = spm_pkg::FIFO_WIDTH,
  parameter int DEPTH = spm_pkg::FIFO_DEPTH
) (
  input  wire logic             clk,       // system clock
  input  wire logic             rst_n,     // sync reset
  input  wire logic             ce,        // clock enable
  input  wire logic             in_valid,  // write request
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output var  logic             in_ready,  // room for a word
  output var  logic             out_valid, // word available
  output logic      [WIDTH-1:0] out_data,  // head word
  input  wire logic             out_ready  // consumer takes head
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push       = in_valid && in_ready;
  assign pop        = out_ready && out_valid;
  assign out_data   = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  fifo_count_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    push && !pop |=> count == $past(count) + 1'b1)
    else $error("fifo count did not follow a push");
endmodule
`default_nettype wire

// >>> spm_clkgen.sv
`timescale 1ns/1ns
`default_nettype none
module spm_clkgen (
  input  wire logic       clk,   // system clock
  input  wire logic       rst_n, // sync reset
  input  wire logic       ce,    // clock enable
  input  wire logic       run,   // generate while high
  input  wire logic [7:0] half,  // half period in cycles
  output var  logic       clk_o, // generated clock
  output var  logic       rise,  // clk_o just rose
  output var  logic       fall   // clk_o just fell
);
  logic [7:0] cnt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt   <= 8'h00;
      clk_o <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt   <= 8'h00;
        clk_o <= 1'b0;
        rise  <= 1'b0;
        fall  <= 1'b0;
      end else if (cnt >= half - 8'h01) begin
        cnt   <= 8'h00;
        clk_o <= ~clk_o;
        rise  <= ~clk_o;
        fall  <= clk_o;
      end else begin
        cnt  <= cnt + 8'h01;
        rise <= 1'b0;
        fall <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> spm_mac_model.sv
`timescale 1ns/1ns
`default_nettype none
// external MAC facing the port in MII PHY role
module spm_mac_model (
  input  wire logic       gclk, // device generated clock
  input  wire logic       dv,   // device rx valid
  input  wire logic [3:0] rxd,  // device rx nibble
  output var  logic       en,   // to device tx enable
  output var  logic [3:0] txd   // to device tx nibble
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [3:0] lo;
  logic       half;
  logic       rhalf;
  initial begin
    en = 1'b0;
    txd = 4'h5;
    half = 1'b0;
    rhalf = 1'b0;
  end
  // low nibble first on both paths
  always @(posedge gclk) begin
    if (dv) begin
      if (!rhalf) lo = rxd;
      else rx_q.push_back({rxd, lo});
      rhalf = !rhalf;
    end else rhalf = 1'b0;
  end
  // change on the same fall the device samples on; idle data keeps moving
  always @(negedge gclk) begin
    if (tx_q.size() != 0) begin
      en <= 1'b1;
      txd <= half ? tx_q[0][7:4] : tx_q[0][3:0];
      if (half) void'(tx_q.pop_front());
      half = !half;
    end else begin
      en <= 1'b0;
      txd <= ~txd;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, xtal = 0, role = 1, spd = 0, thi = 0, tlo = 0, spd10 = 0;
  logic [7:0] sw_data = 8'h00;
  logic sw_last = 0, sw_valid = 0, saw_full = 0, saw_end = 0;
  wire logic tx_clk_o, tx_oe, rx_clk_o, rx_oe, tx_en, rx_dv, rx_er, rdy;
  wire logic [3:0] txd, rxd;
  wire logic [7:0] rx_data;
  wire logic rx_err, rx_valid, rx_end, cfg_rdy, phy_role, clk_out, warn, unsup;
  wire logic [1:0] cfg_type, cfg_speed;
  wire logic gclk = rx_oe & rx_clk_o;
  logic [7:0] got_q[$];
  int fail_count = 0, compares = 0, cycles = 0;
  spm_media_if u_dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .SPEED_10(spd10),
    .ROLE_OR_CLOCK_SOURCE_STRAP(role), .SPEED_SELECT_STRAP(spd),
    .INTERFACE_TYPE_STRAP_HI(thi), .INTERFACE_TYPE_STRAP_LO(tlo),
    .CRYSTAL_CLOCK_INPUT(xtal), .TX_CLK_I(1'b0), .TX_CLK_O(tx_clk_o), .TX_CLK_OE(tx_oe),
    .RX_CLK_I(1'b0), .RX_CLK_O(rx_clk_o), .RX_CLK_OE(rx_oe), .TX_EN(tx_en), .TX_ER(1'b0),
    .TXD(txd), .RX_DV(rx_dv), .RX_ER(rx_er), .RXD(rxd), .SW_TX_DATA(sw_data),
    .SW_TX_LAST(sw_last), .SW_TX_VALID(sw_valid), .SW_TX_READY(rdy), .SW_RX_DATA(rx_data),
    .SW_RX_ERR(rx_err), .SW_RX_VALID(rx_valid), .SW_RX_END(rx_end), .CFG_READY(cfg_rdy),
    .CFG_TYPE(cfg_type), .CFG_PHY_ROLE(phy_role), .CFG_CLK_OUT(clk_out), .CFG_SPEED(cfg_speed),
    .CFG_SPEED_WARN(warn), .CFG_UNSUPPORTED(unsup));
  spm_mac_model u_mac (.gclk(gclk), .dv(rx_dv), .rxd(rxd), .en(tx_en), .txd(txd));
  initial forever #5 clk = ~clk;
  initial forever #20 xtal = ~xtal;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx_valid === 1'b1) got_q.push_back(rx_data);
    if (rx_end === 1'b1) saw_end <= 1'b1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic do_reset(input logic [1:0] ty, input logic r, input logic s);
    int n;
    @(negedge clk);
    rst_n = 0;
    {thi, tlo} = ty;
    role = r;
    spd = s;
    repeat (5) @(negedge clk);
    rst_n = 1;
    for (n = 0; n < 50 && cfg_rdy !== 1'b1; n++) begin
      check({rx_dv, rx_oe, tx_oe}, 8'h00, "active before config");
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
    check({7'h00, cfg_rdy}, 8'h01, "config not caught");
  endtask
  task automatic push(input logic [7:0] b, input logic last);
    @(negedge clk);
    sw_data = b;
    sw_last = last;
    sw_valid = 1;
    while (rdy !== 1'b1) begin
      saw_full = 1;
      @(negedge clk);
    end
  endtask
  task automatic t_mii_phy;
    do_reset(2'b00, 1'b1, 1'b0);
    check({6'h00, cfg_type}, {6'h00, spm_pkg::SPM_MII}, "type");
    check({7'h00, phy_role}, 8'h01, "role");
    check({6'h00, cfg_speed}, {6'h00, spm_pkg::SPD_100}, "speed");
    check({tx_oe, rx_oe, unsup, warn}, 8'h0C, "clock drive");
    {thi, tlo, role} = 3'b110;
    repeat (4) @(negedge clk);
    check({6'h00, cfg_type}, {6'h00, spm_pkg::SPM_MII}, "type not held");
    $display("test mii phy done");
  endtask
  task automatic t_egress;
    int i;
    for (i = 0; i < 10; i++) push(8'hA0 + 8'(i), i == 9);
    @(negedge clk);
    sw_valid = 0;
    check({7'h00, saw_full}, 8'h01, "fifo never full");
    for (i = 0; i < 1000 && u_mac.rx_q.size() < 10; i++) @(negedge clk);
    check(8'(u_mac.rx_q.size()), 8'h0A, "egress count");
    for (i = 0; i < 10 && i < u_mac.rx_q.size(); i++)
      check(u_mac.rx_q[i], 8'hA0 + 8'(i), "egress byte");
    check({7'h00, rx_er}, 8'h00, "egress error");
    $display("test egress done");
  endtask
  task automatic t_ingress;
    int i;
    u_mac.tx_q = '{8'h3C, 8'hE1, 8'h7F};
    repeat (300) @(negedge clk);
    check(8'(got_q.size()), 8'h03, "ingress count");
    for (i = 0; i < 3 && i < got_q.size(); i++)
      check(got_q[i], i == 0 ? 8'h3C : i == 1 ? 8'hE1 : 8'h7F, "ingress byte");
    check({7'h00, saw_end}, 8'h01, "no frame end");
    check({7'h00, rx_err}, 8'h00, "ingress error");
    $display("test ingress done");
  endtask
  task automatic t_others;
    int t;
    do_reset(2'b00, 1'b0, 1'b1);
    check({phy_role, tx_oe, rx_oe, warn}, 8'h01, "mac role");
    check({6'h00, cfg_speed}, {6'h00, spm_pkg::SPD_100}, "mii gigabit");
    spd10 = 1;
    do_reset(2'b00, 1'b1, 1'b0);
    check({6'h00, cfg_speed}, {6'h00, spm_pkg::SPD_10}, "mii 10");
    t = 0;
    repeat (80) begin
      @(negedge clk);
      t += tx_clk_o;
    end
    check(8'(t), 8'h28, "mii clock not 2.5 MHz");
    spd10 = 0;
    do_reset(2'b01, 1'b1, 1'b0);
    check({clk_out, rx_oe, tx_oe}, 8'h00, "rmii ref in");
    do_reset(2'b01, 1'b0, 1'b0);
    repeat (20) @(negedge clk);
    check({6'h00, cfg_type}, {6'h00, spm_pkg::SPM_RMII}, "rmii type");
    check({clk_out, rx_oe, tx_oe}, 8'h06, "rmii clock out");
    t = 0;
    repeat (8) begin
      @(negedge clk);
      t += rx_clk_o;
    end
    check(8'(t), 8'h04, "reference not 50 MHz");
    do_reset(2'b11, 1'b1, 1'b1);
    check({6'h00, cfg_speed, unsup}, 8'h05, "rgmii gigabit");
    repeat (20) @(negedge clk);
    check({rx_dv, rx_oe, tx_oe}, 8'h00, "rgmii quiet");
    $display("test other modes done");
  endtask
  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    t_mii_phy();
    t_egress();
    t_ingress();
    t_others();
    test_done();
  end
endmodule
`default_nettype wire
